// ---- design/ppmu_decode.sv ----
// instruction decoder for the partitioned pixel multiply unit
// assumes a full 32-bit instruction word from the issue logic
`timescale 1ns/1ps

module ppmu_decode
  import ppmu_pkg::*;
(
  input ppmu_instr_t instr,
  output ppmu_op_t op,
  output logic hit
);

  logic group_ok;

  always_comb begin
    group_ok = (instr.format_field == PPMU_FORMAT) &&
               (instr.primary_field == PPMU_PRIMARY);
    op = OP_NONE;
    if (group_ok) begin
      case (instr.opext_field)
        OPX_COEF: op = OP_COEF;
        OPX_UPPER_ALPHA: op = OP_UPPER_ALPHA;
        OPX_LOWER_ALPHA: op = OP_LOWER_ALPHA;
        OPX_SIGNED_HIGH: op = OP_SIGNED_HIGH;
        OPX_UNSIGNED_LOW: op = OP_UNSIGNED_LOW;
        OPX_WIDE_SIGNED_HIGH: op = OP_WIDE_SIGNED_HIGH;
        OPX_WIDE_UNSIGNED_LOW: op = OP_WIDE_UNSIGNED_LOW;
        default: op = OP_NONE;
      endcase
    end
    hit = (op != OP_NONE);
  end

endmodule

// ---- design/ppmu_lane.sv ----
// one 8-bit by 16-bit lane multiplier with the four result shapings
// assumes operands are already selected; purely combinational
`timescale 1ns/1ps

module ppmu_lane
  import ppmu_pkg::*;
(
  input logic [7:0] byte_in,
  input logic byte_signed,
  input logic [15:0] coef,
  input ppmu_rnd_t rnd,
  output logic [31:0] res
);

  logic signed [8:0] b_ext;
  logic signed [24:0] prod_full;
  logic [23:0] prod;
  logic [31:0] sext;
  logic [24:0] r8;
  logic [31:0] r16;

  always_comb begin
    // 9-bit signed covers both byte kinds without a second multiplier
    b_ext = byte_signed ? {byte_in[7], byte_in} : {1'b0, byte_in};
    prod_full = b_ext * $signed(coef);
    // magnitude never exceeds 23 bits, so the cut is lossless
    prod = prod_full[23:0];
    sext = {{8{prod[23]}}, prod};
    // no overflow: largest product plus bias still fits 24 bits
    r8 = {prod[23], prod} + POINT8_BIAS;
    r16 = sext + UPPER16_BIAS;
    unique case (rnd)
      RND_POINT8: res = {16'h0000, r8[23:8]};
      RND_UPPER16: res = {16'h0000, r16[31:16]};
      RND_SHIFT8: res = {prod, 8'h00};
      RND_SEXT: res = sext;
    endcase
  end

endmodule

// ---- design/ppmu_pkg.sv ----
// constants, types and decode helpers for the partitioned pixel multiply unit
// assumes one core clock; issue logic and register file run on the same clock
package ppmu_pkg;

  // instruction word layout
  typedef struct packed {
    logic [1:0] format_field;
    logic [4:0] dest_field;
    logic [5:0] primary_field;
    logic [4:0] first_source_field;
    logic [8:0] opext_field;
    logic [4:0] second_source_field;
  } ppmu_instr_t;

  localparam logic [1:0] PPMU_FORMAT = 2'h2;
  localparam logic [5:0] PPMU_PRIMARY = 6'h36;

  // opcode extension values
  localparam logic [8:0] OPX_COEF = 9'h031;
  localparam logic [8:0] OPX_UPPER_ALPHA = 9'h033;
  localparam logic [8:0] OPX_LOWER_ALPHA = 9'h035;
  localparam logic [8:0] OPX_SIGNED_HIGH = 9'h036;
  localparam logic [8:0] OPX_UNSIGNED_LOW = 9'h037;
  localparam logic [8:0] OPX_WIDE_SIGNED_HIGH = 9'h038;
  localparam logic [8:0] OPX_WIDE_UNSIGNED_LOW = 9'h039;

  // lane geometry
  localparam int NUM_LANES = 4;
  localparam int NUM_WIDE = 2;
  localparam int BYTE_W = 8;
  localparam int LANE_W = 16;
  localparam int WIDE_W = 32;
  localparam int DATA_W = 64;
  localparam int ALPHA_HI_LSB = 16;
  localparam int HIGH_BYTE_OFS = 8;

  // rounding biases: half of the dropped part, ties go upward
  localparam logic [24:0] POINT8_BIAS = 25'h0000080;
  localparam logic [31:0] UPPER16_BIAS = 32'h00008000;

  // fixed latencies in core cycles, issue edge to answer
  localparam int LAT_EXEC = 3;
  localparam int LAT_REFUSE = 1;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_COEF = 3'b001,
    OP_UPPER_ALPHA = 3'b010,
    OP_LOWER_ALPHA = 3'b011,
    OP_SIGNED_HIGH = 3'b100,
    OP_UNSIGNED_LOW = 3'b101,
    OP_WIDE_SIGNED_HIGH = 3'b110,
    OP_WIDE_UNSIGNED_LOW = 3'b111
  } ppmu_op_t;

  typedef enum logic [1:0] {
    RND_POINT8 = 2'b00,
    RND_UPPER16 = 2'b01,
    RND_SHIFT8 = 2'b10,
    RND_SEXT = 2'b11
  } ppmu_rnd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b10,
    ST_DONE = 2'b11
  } ppmu_state_t;

  typedef struct packed {
    logic fpu_present;
    logic processor_float_enable_bit;
    logic float_regs_enable_bit;
  } ppmu_status_t;

  typedef struct packed {
    logic float_unit_off_trap;
    logic unsupported;
    logic wrote;
  } ppmu_done_t;

  function automatic logic src1_is_dbl(input ppmu_op_t op);
    return (op == OP_SIGNED_HIGH) || (op == OP_UNSIGNED_LOW);
  endfunction

  function automatic logic src2_is_dbl(input ppmu_op_t op);
    return (op == OP_COEF) || (op == OP_SIGNED_HIGH) || (op == OP_UNSIGNED_LOW);
  endfunction

  function automatic logic is_wide(input ppmu_op_t op);
    return (op == OP_WIDE_SIGNED_HIGH) || (op == OP_WIDE_UNSIGNED_LOW);
  endfunction

endpackage

// ---- design/ppmu_top.sv ----
// partitioned pixel multiply unit: decode, operand read, lane multiply, write-back
// assumes issue logic and register file share clk; read data arrives one
// cycle after rf_rd_en; single-width values sit in the low 32 bits
//
// Summary of operation
// - decode three pixel-by-coefficient opcode extensions
// - decode two split-byte 64-bit source multiplies
// - decode two widening split-byte multiplies
// - trap instead of executing when float disabled
// - bytes zero-extended, coefficients sign-extended
// - four source bytes times four coefficient lanes
// - round at bit eight, keep top sixteen
// - upper alpha: high coefficient for all lanes
// - lower alpha: low coefficient for all lanes
// - signed high bytes times coefficient lanes
// - round to nearest, ties upward, top sixteen
// - unsigned low bytes times coefficient lanes
// - sign-extend, round upper sixteen, ties upward
// - widening signed: product shifted left eight
// - widening unsigned: product sign-extended to 32
`timescale 1ns/1ps

module ppmu_top
  import ppmu_pkg::*;
(
  input logic clk,
  input logic rst_b,
  input logic issue_valid,
  output logic issue_ready,
  input ppmu_instr_t issue_instr,
  input ppmu_status_t core_status,
  output logic rf_rd_en,
  output logic [4:0] rf_rd_addr1,
  output logic rf_rd_dbl1,
  output logic [4:0] rf_rd_addr2,
  output logic rf_rd_dbl2,
  input logic [63:0] rf_rd_data1,
  input logic [63:0] rf_rd_data2,
  output logic wb_en,
  output logic [4:0] wb_addr,
  output logic [63:0] wb_data,
  output logic done_valid,
  output ppmu_done_t done_info
);

  // reset release; asserts at once, leaves on a clock edge so that no
  // flop comes out of reset a cycle ahead of its neighbours
  logic [1:0] rst_sync_q;
  logic [1:0] rst_sync_d;
  logic rst_sync_b;

  always_comb begin
    rst_sync_d = {rst_sync_q[0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= rst_sync_d;
    end
  end

  assign rst_sync_b = rst_sync_q[1];

  // decode of the incoming word; combinational, the op lives on in op_q
  ppmu_op_t dec_op;
  logic dec_hit;

  ppmu_decode u_decode (
    .instr(issue_instr),
    .op(dec_op),
    .hit(dec_hit)
  );

  // control state
  ppmu_state_t state_q;
  ppmu_state_t state_d;
  ppmu_op_t op_q;
  ppmu_op_t op_d;
  logic [4:0] dest_q;
  logic [4:0] dest_d;
  logic [4:0] src1_q;
  logic [4:0] src1_d;
  logic [4:0] src2_q;
  logic [4:0] src2_d;
  logic dbl1_q;
  logic dbl1_d;
  logic dbl2_q;
  logic dbl2_d;
  ppmu_done_t info_q;
  ppmu_done_t info_d;
  logic [63:0] result_q;
  logic [63:0] result_d;

  logic fp_off;
  logic take;
  logic in_done;

  // datapath nets
  logic [63:0] s1;
  logic [63:0] s2;
  logic [7:0] lane_byte [NUM_LANES];
  logic [15:0] lane_coef [NUM_LANES];
  logic [31:0] lane_res [NUM_LANES];
  logic lane_signed;
  ppmu_rnd_t lane_rnd;
  logic [63:0] packed_res;

  // low from the taking edge until the done cycle has passed: one op at a time
  assign issue_ready = (state_q == ST_IDLE) && rst_sync_b;
  assign take = issue_valid && issue_ready;
  // any one of the three conditions blocks execution
  // status counts only on the issue edge; a later change cannot abort an op
  assign fp_off = !core_status.processor_float_enable_bit ||
                  !core_status.float_regs_enable_bit ||
                  !core_status.fpu_present;

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    dest_d = dest_q;
    src1_d = src1_q;
    src2_d = src2_q;
    dbl1_d = dbl1_q;
    dbl2_d = dbl2_q;
    info_d = info_q;
    result_d = result_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          dest_d = issue_instr.dest_field;
          src1_d = issue_instr.first_source_field;
          src2_d = issue_instr.second_source_field;
          op_d = dec_op;
          // width of each read follows the op, not the register number
          dbl1_d = src1_is_dbl(dec_op);
          dbl2_d = src2_is_dbl(dec_op);
          info_d = '0;
          if (!dec_hit) begin
            // not one of ours: answer at once, touch nothing
            info_d.unsupported = 1'b1;
            state_d = ST_DONE;
          end else if (fp_off) begin
            // trap wins before any register read is made
            info_d.float_unit_off_trap = 1'b1;
            state_d = ST_DONE;
          end else begin
            state_d = ST_READ;
          end
        end
      end
      ST_READ: begin
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        // read data stands for this cycle only, so the result is caught here
        result_d = packed_res;
        info_d.wrote = 1'b1;
        state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // every control flop clears, so a reset mid-op drops it with no write
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      dest_q <= 5'h00;
      src1_q <= 5'h00;
      src2_q <= 5'h00;
      dbl1_q <= 1'b0;
      dbl2_q <= 1'b0;
      info_q <= '0;
      result_q <= 64'h0000000000000000;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      dest_q <= dest_d;
      src1_q <= src1_d;
      src2_q <= src2_d;
      dbl1_q <= dbl1_d;
      dbl2_q <= dbl2_d;
      info_q <= info_d;
      result_q <= result_d;
    end
  end

  // register file read port
  assign rf_rd_en = (state_q == ST_READ);
  assign rf_rd_addr1 = src1_q;
  assign rf_rd_addr2 = src2_q;
  assign rf_rd_dbl1 = dbl1_q;
  assign rf_rd_dbl2 = dbl2_q;

  // read data is valid during exec and comes from same-clock logic
  assign s1 = rf_rd_data1;
  assign s2 = rf_rd_data2;

  // per-instruction lane shaping
  always_comb begin
    lane_signed = 1'b0;
    lane_rnd = RND_POINT8;
    case (op_q)
      OP_COEF, OP_UPPER_ALPHA, OP_LOWER_ALPHA: begin
        lane_rnd = RND_POINT8;
      end
      OP_SIGNED_HIGH: begin
        lane_signed = 1'b1;
        lane_rnd = RND_POINT8;
      end
      OP_UNSIGNED_LOW: begin
        lane_rnd = RND_UPPER16;
      end
      OP_WIDE_SIGNED_HIGH: begin
        lane_signed = 1'b1;
        lane_rnd = RND_SHIFT8;
      end
      OP_WIDE_UNSIGNED_LOW: begin
        lane_rnd = RND_SEXT;
      end
      default: begin
        lane_rnd = RND_POINT8;
      end
    endcase
  end

  // operand selection; lane i of each source feeds lane i, except in the alpha forms, where one coefficient feeds all four lanes
  // wide forms read lanes 0 and 1 only; the upper two run idle
  generate
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_sel
      always_comb begin
        lane_byte[g] = s1[g*BYTE_W +: BYTE_W];
        lane_coef[g] = s2[g*LANE_W +: LANE_W];
        case (op_q)
          OP_UPPER_ALPHA: begin
            lane_coef[g] = s2[ALPHA_HI_LSB +: LANE_W];
          end
          OP_LOWER_ALPHA: begin
            lane_coef[g] = s2[0 +: LANE_W];
          end
          OP_SIGNED_HIGH, OP_WIDE_SIGNED_HIGH: begin
            lane_byte[g] = s1[g*LANE_W + HIGH_BYTE_OFS +: BYTE_W];
          end
          OP_UNSIGNED_LOW, OP_WIDE_UNSIGNED_LOW: begin
            lane_byte[g] = s1[g*LANE_W +: BYTE_W];
          end
          default: begin
            lane_byte[g] = s1[g*BYTE_W +: BYTE_W];
          end
        endcase
      end
    end
  endgenerate

  // one multiplier per lane; lanes share no carry path
  generate
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      ppmu_lane u_lane (
        .byte_in(lane_byte[g]),
        .byte_signed(lane_signed),
        .coef(lane_coef[g]),
        .rnd(lane_rnd),
        .res(lane_res[g])
      );
    end
  endgenerate

  // result packing; wide forms use only the two low lanes
  // upper halves of both 32-bit sources never reach the result
  always_comb begin
    packed_res = 64'h0000000000000000;
    if (is_wide(op_q)) begin
      for (int i = 0; i < NUM_WIDE; i++) begin
        packed_res[i*WIDE_W +: WIDE_W] = lane_res[i];
      end
    end else begin
      for (int i = 0; i < NUM_LANES; i++) begin
        packed_res[i*LANE_W +: LANE_W] = lane_res[i][LANE_W-1:0];
      end
    end
  end

  // answer to the issue logic
  assign in_done = (state_q == ST_DONE);
  assign done_valid = in_done;
  assign done_info = info_q;
  // refused ops answer without a write, so the file keeps its old value
  assign wb_en = in_done && info_q.wrote;
  assign wb_addr = dest_q;
  assign wb_data = result_q;

endmodule

// ---- verif/ppmu_bench.sv ----
// self-checking bench for the pixel multiply unit
// assumes the register file model answers every read
`timescale 1ns/1ps
module ppmu_bench
  import ppmu_pkg::*;
;
  logic clk, rst_b, issue_valid, issue_ready, rf_rd_en, rf_rd_dbl1, rf_rd_dbl2, wb_en;
  logic done_valid, saw_rd, wen_q;
  ppmu_instr_t issue_instr;
  ppmu_status_t core_status;
  ppmu_done_t done_info, info_q;
  logic [4:0] rf_rd_addr1, rf_rd_addr2, wb_addr, wa_q;
  logic [63:0] rf_rd_data1, rf_rd_data2, wb_data, wd_q;
  logic [11:0] rd_q;
  int lat;
  int mismatches = 0;
  int checks_done = 0;
  ppmu_top i_dut(.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue_instr(issue_instr), .core_status(core_status),
    .rf_rd_en(rf_rd_en), .rf_rd_addr1(rf_rd_addr1), .rf_rd_dbl1(rf_rd_dbl1),
    .rf_rd_addr2(rf_rd_addr2), .rf_rd_dbl2(rf_rd_dbl2), .rf_rd_data1(rf_rd_data1),
    .rf_rd_data2(rf_rd_data2), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data),
    .done_valid(done_valid), .done_info(done_info));
  ppmu_regfile_model i_rf(.clk(clk), .rf_rd_en(rf_rd_en), .rf_rd_addr1(rf_rd_addr1),
    .rf_rd_dbl1(rf_rd_dbl1), .rf_rd_addr2(rf_rd_addr2), .rf_rd_dbl2(rf_rd_dbl2),
    .rf_rd_data1(rf_rd_data1), .rf_rd_data2(rf_rd_data2));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [63:0] ref_mul(input logic [8:0] x, input logic [63:0] a,
    input logic [63:0] b);
    logic [63:0] r;
    int u, c, p;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      if (x < 9'h036) u = a[8*i +: 8];
      else if (x[0]) u = a[16*i +: 8];
      else u = $signed(a[16*i+8 +: 8]);
      c = $signed(x == 9'h033 ? b[31:16] : x == 9'h035 ? b[15:0] : b[16*i +: 16]);
      p = u * c;
      if (x == 9'h037) r[16*i +: 16] = 16'((p + 32768) >>> 16);
      else if (x == 9'h038 && i < 2) r[32*i +: 32] = 32'(p <<< 8);
      else if (x == 9'h039 && i < 2) r[32*i +: 32] = 32'(p);
      else if (x < 9'h038) r[16*i +: 16] = 16'((p + 128) >>> 8);
    end
    return r;
  endfunction
  // issue one op, then watch the answer for a bounded number of cycles
  task automatic run(input ppmu_instr_t ins, input ppmu_status_t st);
    int n;
    @(posedge clk);
    issue_instr <= ins;
    core_status <= st;
    issue_valid <= 1'b1;
    @(negedge clk);
    for (n = 0; n < 20 && issue_ready !== 1'b1; n++) @(negedge clk);
    if (n == 20) begin
      mismatches++;
      finish_test();
    end
    @(posedge clk);
    issue_valid <= 1'b0;
    saw_rd = 1'b0;
    for (lat = 1; lat < 10; lat++) begin
      @(negedge clk);
      if (rf_rd_en === 1'b1) saw_rd = 1'b1;
      if (rf_rd_en === 1'b1) rd_q = {rf_rd_addr1, rf_rd_dbl1, rf_rd_addr2, rf_rd_dbl2};
      if (done_valid === 1'b1) break;
    end
    if (lat == 10) begin
      mismatches++;
      finish_test();
    end
    wen_q = wb_en;
    wa_q = wb_addr;
    wd_q = wb_data;
    info_q = done_info;
  endtask
  task automatic t_execute();
    logic [8:0] ops [7] = '{9'h031, 9'h033, 9'h035, 9'h036, 9'h037, 9'h038, 9'h039};
    logic [8:0] x;
    logic [4:0] s;
    for (int k = 0; k < 14; k++) begin
      x = ops[k % 7];
      s = 5'(1 + (k % 2) * 2);
      run({2'h2, 5'(k + 8), 6'h36, s, x, 5'(s + 1)}, 3'h7);
      chk(lat, 3);
      chk(rd_q, {s, (x inside {9'h036, 9'h037}), 5'(s + 1), (x inside {9'h031, 9'h036, 9'h037})});
      chk({wen_q, wa_q, info_q}, {1'b1, 5'(k + 8), 3'h1});
      chk(wd_q, ref_mul(x, i_rf.mem[s], i_rf.mem[s + 1]));
    end
  endtask
  task automatic t_refuse();
    ppmu_status_t st [3] = '{3'h6, 3'h5, 3'h3};
    ppmu_instr_t ins;
    for (int i = 0; i < 7; i++) begin
      ins = {2'h2, 5'h1f, 6'h36, 5'h01, 9'h031, 5'h02};
      case (i)
        3: ins.opext_field = 9'h032;
        4: ins.opext_field = 9'h03a;
        5: ins.primary_field = 6'h34;
        6: ins.format_field = 2'h3;
        default: ;
      endcase
      run(ins, i < 3 ? st[i] : (i == 3 ? 3'h0 : 3'h7));
      chk(lat, 1);
      chk({saw_rd, wen_q, info_q}, {2'h0, i < 3 ? 3'h4 : 3'h2});
    end
  endtask
  // reset pulled in the read cycle of an op: no write may follow, and the
  // first op after release must run normally
  task automatic t_reset();
    @(posedge clk);
    issue_instr <= {2'h2, 5'h05, 6'h36, 5'h01, 9'h031, 5'h02};
    issue_valid <= 1'b1;
    @(posedge clk);
    issue_valid <= 1'b0;
    rst_b <= 1'b0;
    @(negedge clk);
    chk({issue_ready, rf_rd_en, wb_en, done_valid, done_info, wb_addr, rf_rd_addr1}, 17'h0);
    chk(wb_data, 64'h0);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge clk);
    chk(issue_ready, 1'b0);
    run({2'h2, 5'h06, 6'h36, 5'h03, 9'h033, 5'h04}, 3'h7);
    chk(lat, 3);
    chk({wen_q, wa_q, info_q}, {1'b1, 5'h06, 3'h1});
    chk(wd_q, ref_mul(9'h033, i_rf.mem[3], i_rf.mem[4]));
  endtask
  initial begin
    rst_b = 1'b0;
    issue_valid = 1'b0;
    issue_instr = '0;
    core_status = 3'h7;
    i_rf.mem[1] = 64'h7f80_01ff_ff01_8001;
    i_rf.mem[2] = 64'hff80_0080_8000_7fff;
    i_rf.mem[3] = 64'h80ff_40c0_00ff_0180;
    i_rf.mem[4] = 64'h0100_ff7f_7fff_8001;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_execute();
    t_refuse();
    t_reset();
    finish_test();
  end
endmodule
bind ppmu_top ppmu_top_properties i_props(.clk(clk), .rst_b(rst_b),
  .issue_valid(issue_valid), .issue_ready(issue_ready), .issue_instr(issue_instr),
  .core_status(core_status), .rf_rd_en(rf_rd_en), .rf_rd_addr1(rf_rd_addr1),
  .rf_rd_dbl1(rf_rd_dbl1), .rf_rd_addr2(rf_rd_addr2), .rf_rd_dbl2(rf_rd_dbl2),
  .rf_rd_data1(rf_rd_data1),
  .rf_rd_data2(rf_rd_data2), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data),
  .done_valid(done_valid), .done_info(done_info));

// ---- verif/ppmu_regfile_model.sv ----
// register file stand-in: answers a read one cycle after the request
// assumes 32 doubles; single reads carry the value in the low half
`timescale 1ns/1ps
module ppmu_regfile_model (
  input logic clk,
  input logic rf_rd_en,
  input logic [4:0] rf_rd_addr1,
  input logic rf_rd_dbl1,
  input logic [4:0] rf_rd_addr2,
  input logic rf_rd_dbl2,
  output logic [63:0] rf_rd_data1,
  output logic [63:0] rf_rd_data2
);
  logic [63:0] mem [32];
  // single reads put junk in the upper half, which the unit must ignore
  function automatic logic [63:0] fetch(input logic [4:0] a, input logic dbl);
    return dbl ? mem[a] : {~mem[a][31:0], mem[a][31:0]};
  endfunction
  // one process owns the read data: cleared at start, then clocked
  initial begin
    rf_rd_data1 = '0;
    rf_rd_data2 = '0;
    forever begin
      @(posedge clk);
      if (rf_rd_en) begin
        rf_rd_data1 <= fetch(rf_rd_addr1, rf_rd_dbl1);
        rf_rd_data2 <= fetch(rf_rd_addr2, rf_rd_dbl2);
      end else begin
        // valid for one cycle only, then toggles so stale use shows
        rf_rd_data1 <= ~rf_rd_data1;
        rf_rd_data2 <= ~rf_rd_data2;
      end
    end
  end
endmodule

// ---- verif/ppmu_top_properties.sv ----
// assertion checker on the pixel multiply unit top ports
// assumes a bind to ppmu_top; one clock, active low reset
`timescale 1ns/1ps
module ppmu_top_properties
  import ppmu_pkg::*;
(
  input logic clk,
  input logic rst_b,
  input logic issue_valid,
  input logic issue_ready,
  input ppmu_instr_t issue_instr,
  input ppmu_status_t core_status,
  input logic rf_rd_en,
  input logic [4:0] rf_rd_addr1,
  input logic rf_rd_dbl1,
  input logic [4:0] rf_rd_addr2,
  input logic rf_rd_dbl2,
  input logic [63:0] rf_rd_data1,
  input logic [63:0] rf_rd_data2,
  input logic wb_en,
  input logic [4:0] wb_addr,
  input logic [63:0] wb_data,
  input logic done_valid,
  input ppmu_done_t done_info
);
  logic known, take, rd_q;
  ppmu_instr_t ins_q;
  logic [63:0] d1_q, d2_q;
  logic signed [23:0] ps, pu, pr;
  assign known = issue_instr.format_field == 2'h2 && issue_instr.primary_field == 6'h36
    && issue_instr.opext_field inside {9'h031, 9'h033, [9'h035:9'h039]};
  assign take = issue_valid && issue_ready;
  assign ps = $signed(d1_q[15:8]) * $signed(d2_q[15:0]);
  assign pu = $signed({1'b0, d1_q[7:0]}) * $signed(d2_q[15:0]);
  assign pr = pu + 24'sh80;
  // operands latched as the unit reads them, to judge lane 0 of the write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 1'b0;
      ins_q <= '0;
      d1_q <= '0;
      d2_q <= '0;
    end else begin
      rd_q <= rf_rd_en;
      if (take) ins_q <= issue_instr;
      if (rd_q) begin
        d1_q <= rf_rd_data1;
        d2_q <= rf_rd_data2;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  exec_path_a:
    assert property (take && known && &core_status |=> rf_rd_en ##1 !rf_rd_en ##1
      done_valid && wb_en && done_info == 3'h1) else $error("executed op misses read or write");
  float_trap_a:
    assert property (take && known && !(&core_status) |=> done_valid && !wb_en && !rf_rd_en
      && done_info == 3'h4) else $error("disabled unit did not trap");
  unknown_op_a:
    assert property (take && !known |=> done_valid && !wb_en && !rf_rd_en
      && done_info == 3'h2) else $error("unknown op not flagged");
  read_fields_a:
    assert property (rf_rd_en |-> rf_rd_addr1 == ins_q.first_source_field
      && rf_rd_addr2 == ins_q.second_source_field
      && rf_rd_dbl1 == (ins_q.opext_field inside {9'h036, 9'h037})
      && rf_rd_dbl2 == (ins_q.opext_field inside {9'h031, 9'h036, 9'h037}))
      else $error("read fields wrong");
  busy_ready_a:
    assert property (take |=> !issue_ready) else $error("ready high while busy");
  done_ready_a:
    assert property (done_valid |-> !issue_ready ##1 issue_ready)
      else $error("ready not back after done");
  dest_field_a:
    assert property (wb_en |-> wb_addr == ins_q.dest_field) else $error("write address wrong");
  wide_signed_a:
    assert property (wb_en && ins_q.opext_field == 9'h038 |-> wb_data[31:0] == {ps, 8'h00})
      else $error("wide signed lane wrong");
  wide_unsigned_a:
    assert property (wb_en && ins_q.opext_field == 9'h039 |-> wb_data[31:0] == {{8{pu[23]}}, pu})
      else $error("wide unsigned lane wrong");
  coef_round_a:
    assert property (wb_en && ins_q.opext_field inside {9'h031, 9'h035}
      |-> wb_data[15:0] == pr[23:8]) else $error("rounded lane wrong");
  cover property (take && known && &core_status);
  cover property (done_valid && done_info.float_unit_off_trap);
  cover property (done_valid && done_info.unsupported);
  cover property (wb_en && ins_q.opext_field == 9'h038);
endmodule
